// ===== cpir_regs.sv
// Command, page select and interrupt enable registers with IRQ pin drive.
// Assumes a synchronous host port and request levels from the core.
// What this block does
// - Override set: page supplies A5 and A4
// - Override clear: latch gives whole address
// - Two-bit page used only under override
// - Receiver-off bit disables analog receiver
// - Sleep bit one enters soft power-down
// - Sleep zero wakes; reads one until done
// - Sleep refused during soft reset command
// - Command field starts, reads running command
// - Core updates command field on completion
// - Polarity bit inverts IRQ pin level
// - Polarity resets to one, pin floats
// - Drive mode: push-pull or open drain
// - Enables 6..4 gate tx, rx, idle
// - Enables 3..0 gate fifo, error, timer
// - Reserved bits read zero
`timescale 1ns/100ps
`default_nettype none
`include "cpir_cfg.svh"

module cpir_regs #(
	parameter int WAKE_CYC = `CPIR_WAKE_CYC
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Host register port
	input  wire logic [5:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	// Address latch from host interface
	input  wire logic [5:0] latch_addr,
	output var  logic [5:0] eff_addr,
	// Core command handshake
	input  wire logic       cmd_done,
	output var  logic [3:0] cmd_code,
	output var  logic       cmd_start,
	output var  logic       receiver_analog_off,
	output var  logic       soft_sleep,
	// Interrupt requests and drive mode
	input  wire logic [6:0] irq_requests,
	input  wire logic       irq_drive_mode,
	output var  logic       irq_status,
	output var  logic       irq_o,
	output var  logic       irq_oe
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]          page_q;
	logic [7:0]          ien_q;
	logic                rxoff_q;
	logic [3:0]          code_q;
	cpir_pkg::cpir_pwr_e pwr_q;
	logic [15:0]         wake_cnt_q;
	logic                start_q;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	logic wr_page;
	logic wr_cmd;
	logic wr_ien;
	assign wr_page = reg_wr && hit(reg_addr, `CPIR_OFS_PAGE);
	assign wr_cmd  = reg_wr && hit(reg_addr, `CPIR_OFS_CMD);
	assign wr_ien  = reg_wr && hit(reg_addr, `CPIR_OFS_IEN);

	// ----------------------------------------
	// Page control
	// ----------------------------------------
	// Page reset value
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			page_q <= `CPIR_PAGE_RST;
		end else if (wr_page) begin
			page_q <= {reg_wdata[`CPIR_PAGE_OVR_BIT], 5'h00, reg_wdata[1:0]};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			eff_addr <= 6'h00;
		end else if (page_q[`CPIR_PAGE_OVR_BIT]) begin
			eff_addr <= {page_q[1:0], latch_addr[3:0]};
		end else begin
			eff_addr <= latch_addr;
		end
	end

	// ----------------------------------------
	// Command and power control
	// ----------------------------------------
	// Receiver off control
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxoff_q <= 1'h1;
		end else if (wr_cmd) begin
			rxoff_q <= reg_wdata[`CPIR_CMD_RXOFF];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_q  <= `CPIR_CODE_IDLE;
			start_q <= 1'h0;
		end else if (wr_cmd) begin
			code_q  <= reg_wdata[3:0];
			start_q <= 1'h1;
		end else begin
			start_q <= 1'h0;
			if (cmd_done) begin
				code_q <= `CPIR_CODE_IDLE;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q      <= cpir_pkg::CPIR_PWR_RUN;
			wake_cnt_q <= 16'h0000;
		end else begin
			case (pwr_q)
				cpir_pkg::CPIR_PWR_RUN: begin
					if (wr_cmd && reg_wdata[`CPIR_CMD_SLEEP] && code_q != `CPIR_CODE_SRESET
							&& reg_wdata[3:0] != `CPIR_CODE_SRESET) begin
						pwr_q <= cpir_pkg::CPIR_PWR_SLEEP;
					end
				end
				cpir_pkg::CPIR_PWR_SLEEP: begin
					if (wr_cmd && !reg_wdata[`CPIR_CMD_SLEEP]) begin
						pwr_q      <= cpir_pkg::CPIR_PWR_WAKE;
						wake_cnt_q <= 16'(WAKE_CYC - 1);
					end
				end
				cpir_pkg::CPIR_PWR_WAKE: begin
					if (wake_cnt_q == 16'h0000) begin
						pwr_q <= cpir_pkg::CPIR_PWR_RUN;
					end else begin
						wake_cnt_q <= wake_cnt_q - 16'h0001;
					end
				end
				default: begin
					pwr_q <= cpir_pkg::CPIR_PWR_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_code            <= `CPIR_CODE_IDLE;
			cmd_start           <= 1'h0;
			receiver_analog_off <= 1'h1;
			soft_sleep          <= 1'h0;
		end else begin
			cmd_code            <= code_q;
			cmd_start           <= start_q;
			receiver_analog_off <= rxoff_q;
			soft_sleep          <= (pwr_q != cpir_pkg::CPIR_PWR_RUN);
		end
	end

	// ----------------------------------------
	// Interrupt enable and pin
	// ----------------------------------------
	// Polarity resets high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ien_q <= `CPIR_IEN_RST;
		end else if (wr_ien) begin
			ien_q <= reg_wdata;
		end
	end

	logic irq_any;
	logic pin_level;
	assign irq_any   = |(irq_requests & ien_q[6:0]);
	assign pin_level = irq_any ^ ien_q[`CPIR_IEN_INV_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 1'h0;
			irq_o      <= 1'h0;
			irq_oe     <= 1'h0;
		end else begin
			irq_status <= irq_any;
			irq_o      <= irq_drive_mode ? pin_level : 1'h0;
			irq_oe     <= irq_drive_mode ? 1'h1 : !pin_level;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Reserved bits read zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`CPIR_OFS_PAGE: reg_rdata <= page_q;
				`CPIR_OFS_CMD:  reg_rdata <= {2'h0, rxoff_q,
						pwr_q != cpir_pkg::CPIR_PWR_RUN, code_q};
				`CPIR_OFS_IEN:  reg_rdata <= ien_q;
				`CPIR_OFS_REQ:  reg_rdata <= {irq_any, irq_requests};
				default:        reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : cpir_regs
`default_nettype wire

// ===== cpir_cfg.svh
// Offsets, field positions, reset values and timing for the command/page/irq registers.
// Assumes an 8-bit register port with one-cycle strobes.
`ifndef CPIR_CFG_SVH
`define CPIR_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CPIR_OFS_PAGE      6'h00
`define CPIR_OFS_CMD      6'h01
`define CPIR_OFS_IEN      6'h02
`define CPIR_OFS_REQ      6'h03

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPIR_PAGE_OVR_BIT 7
`define CPIR_CMD_RXOFF    5
`define CPIR_CMD_SLEEP    4
`define CPIR_IEN_INV_BIT  7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPIR_PAGE_RST     8'h00
`define CPIR_CMD_RST      8'h20
`define CPIR_IEN_RST      8'h80
`define CPIR_DRV_RST      1'h0

// ----------------------------------------
// Command codes and wake-up time
// ----------------------------------------
`define CPIR_CODE_IDLE    4'h0
`define CPIR_CODE_SRESET  4'hf
`define CPIR_WAKE_NS      2000
`define CPIR_CLK_NS       25
`define CPIR_WAKE_CYC     ((`CPIR_WAKE_NS + `CPIR_CLK_NS - 1) / `CPIR_CLK_NS)

`endif

// ===== cpir_pkg.sv
// Types for the command/page/irq register block.
// Assumes cpir_cfg.svh is compiled alongside.
package cpir_pkg;

	typedef enum logic [1:0] {
		CPIR_PWR_RUN   = 2'b00,
		CPIR_PWR_SLEEP = 2'b01,
		CPIR_PWR_WAKE  = 2'b10
	} cpir_pwr_e;

endpackage : cpir_pkg

// ===== cpir_core_model.sv
// Core model: ends each started command after lag cycles.
// Assumes cmd_start is a one-cycle pulse; lag 0 never ends.
`timescale 1ns/100ps
`default_nettype none
module cpir_core_model (
	// Handshake
	input  wire logic       core_clk,
	input  wire logic       cmd_start,
	input  wire logic [7:0] lag,
	output var  logic       cmd_done
);
	int cnt = 0;
	initial cmd_done = 1'h0;
	always @(posedge core_clk) begin
		cmd_done <= (cnt == 1);
		cnt <= cmd_start ? int'(lag) : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule : cpir_core_model
`default_nettype wire

// ===== cpir_regs_monitor.sv
// Assertions on cpir_regs ports.
// Assumes the bind below.
`timescale 1ns/100ps
`default_nettype none
module cpir_regs_monitor #(parameter int WAKE_CYC = 3) (
	// Clock and host port
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Core and irq
	input wire logic       cmd_done,
	input wire logic [3:0] cmd_code,
	input wire logic       receiver_analog_off,
	input wire logic       soft_sleep,
	input wire logic [6:0] irq_requests,
	input wire logic       irq_drive_mode,
	input wire logic       irq_status,
	input wire logic       irq_oe
);
	localparam int WMAX = WAKE_CYC + 4;
	logic [6:0]       ien_q;
	wire logic        cw = reg_wr && reg_addr == 6'h01;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) ien_q <= 7'h00;
		else if (reg_wr && reg_addr == 6'h02) ien_q <= reg_wdata[6:0];
	end
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("rdata not idle");
	AST_RXOFF: assert property (cw |-> ##2 receiver_analog_off == $past(reg_wdata[5], 2))
		else $error("rx off wrong");
	AST_REFUSE: assert property (cw && reg_wdata[3:0] == 4'hf && !soft_sleep
		&& !$past(reg_wr) |=> !soft_sleep [*2]) else $error("sleep taken");
	AST_WAKE: assert property (cw && !reg_wdata[4] && soft_sleep
		|=> soft_sleep ##[1:WMAX] !soft_sleep) else $error("wake wrong");
	AST_DONE: assert property (cmd_done && !reg_wr |-> ##2 cmd_code == 4'h0)
		else $error("code kept");
	AST_IRQ_ON: assert property (((irq_requests & ien_q) != 7'h00) [*3] |-> irq_status)
		else $error("irq missing");
	AST_IRQ_OFF: assert property (((irq_requests & ien_q) == 7'h00) [*3] |-> !irq_status)
		else $error("irq leaks");
	AST_PUSH: assert property (irq_drive_mode [*3] |-> irq_oe)
		else $error("pin undriven");
	cover property ($fell(soft_sleep));
	cover property ($rose(irq_status));
	cover property (reg_rd && reg_addr == 6'h00);
endmodule : cpir_regs_monitor
bind cpir_regs cpir_regs_monitor #(.WAKE_CYC(WAKE_CYC)) u_mon (.core_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_done, .cmd_code, .receiver_analog_off,
	.soft_sleep, .irq_requests, .irq_drive_mode, .irq_status, .irq_oe);
`default_nettype wire

// ===== cpir_regs_bench.sv
// Bench for cpir_regs against a register model.
// Assumes the core model and the bound monitor.
`timescale 1ns/100ps
`default_nettype none
module cpir_regs_bench;
	logic       core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, irq_drive_mode = 1'h0;
	logic       cmd_done, cmd_start, rx_off, soft_sleep, irq_status, irq_o, irq_oe;
	logic [5:0] reg_addr = 6'h00, latch_addr = 6'h00, eff_addr;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, lag = 8'h08;
	logic [6:0] irq_requests = 7'h00;
	logic [3:0] cmd_code;
	int         miscompares = 0, samples_checked = 0, m[3] = '{8'h00, 8'h20, 8'h80}, e, k;
	always #12.5 core_clk = ~core_clk;
	cpir_regs #(.WAKE_CYC(3)) DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .latch_addr, .eff_addr, .cmd_done, .cmd_code, .cmd_start, .soft_sleep,
		.receiver_analog_off(rx_off), .irq_requests, .irq_drive_mode, .irq_status, .irq_o, .irq_oe);
	cpir_core_model u_core (.core_clk, .cmd_start, .lag, .cmd_done);
	task automatic chk(input logic [7:0] seen, input logic [7:0] ex, input string what);
		samples_checked++;
		if (seen !== ex) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		if (a == 6'h00) m[0] = d & 8'h83;
		if (a == 6'h02) m[2] = d;
		if (a == 6'h01) m[1] = (d & 8'h2f) | ((d[4] && d[3:0] != 4'hf && m[1][3:0] != 4'hf)
			|| (m[1][4] && !d[4]) ? 8'h10 : 8'h00);
	endtask : wr
	task automatic rd(input logic [5:0] a, input int ex, input string what);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, ex[7:0], what);
	endtask : rd
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	initial begin
		k = $urandom(4229);
		repeat (4) @(posedge core_clk);
		rst_n <= 1'h1;
		for (k = 0; k < 3; k++) rd(k[5:0], m[k], "reset value");
		chk(irq_oe, 8'h00, "irq float");
		rd(6'h3f, 0, "unmapped");
		wr(6'h00, 8'hff);
		rd(6'h00, m[0], "page");
		for (k = 0; k < 8; k++) begin
			e = $urandom;
			wr(6'h00, e[7:0] & 8'h83);
			latch_addr <= e[13:8];
			repeat (2) @(posedge core_clk);
			#1 chk(eff_addr, e[7] ? {e[1:0], e[11:8]} : e[13:8], "eff addr");
		end
		$display("page test done");
		irq_drive_mode <= 1'h1;
		for (k = 0; k < 16; k++) begin
			e = $urandom;
			wr(6'h02, e[7:0]);
			irq_requests <= e[14:8];
			rd(6'h02, m[2], "enable");
			#1 chk(irq_status, |(e[14:8] & e[6:0]), "irq status");
			chk({irq_oe, irq_o}, {1'h1, (|(e[14:8] & e[6:0])) ^ e[7]}, "push pin");
		end
		irq_drive_mode <= 1'h0;
		repeat (3) @(posedge core_clk);
		#1 chk({irq_oe, irq_o}, {!((|(e[14:8] & e[6:0])) ^ e[7]), 1'h0}, "drain pin");
		$display("irq test done");
		wr(6'h01, 8'h05);
		rd(6'h01, m[1], "cmd run");
		chk(rx_off, 8'h00, "rx on");
		repeat (12) @(posedge core_clk);
		m[1] = m[1] & 8'hf0;
		rd(6'h01, m[1], "cmd done");
		wr(6'h01, 8'h3f);
		rd(6'h01, m[1], "sleep refused");
		repeat (12) @(posedge core_clk);
		m[1] = m[1] & 8'hf0;
		rd(6'h01, m[1], "reset cmd done");
		lag <= 8'h01;
		wr(6'h01, 8'h30);
		rd(6'h01, m[1], "sleep");
		wr(6'h01, 8'h20);
		for (k = 0; k < 20 && soft_sleep !== 1'h0; k++) @(posedge core_clk);
		if (k == 20) begin
			miscompares++;
			end_sim;
		end
		rd(6'h01, 8'h20, "awake");
		$display("command test done");
		end_sim;
	end
endmodule : cpir_regs_bench
`default_nettype wire
